/* inc/acw_pkg.sv */
// Shared constants and types for the comparator pair window control block.
// Assumes an Avalon-MM byte address with one 32-bit word per register.
package acw_pkg;

   // ----------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_COMP0_CTRL   = 4'h0;
   localparam logic [3:0] IDX_COMP1_CTRL   = 4'h1;
   localparam logic [3:0] IDX_COMP0_MUX    = 4'h2;
   localparam logic [3:0] IDX_COMP1_MUX    = 4'h3;
   localparam logic [3:0] IDX_ROUTE        = 4'h4;
   localparam logic [3:0] IDX_SCALER       = 4'h5;
   localparam logic [3:0] IDX_WINDOW       = 4'h6;
   localparam logic [3:0] IDX_STATUS       = 4'h7;
   localparam logic [3:0] IDX_CURR_CTRL    = 4'h8;
   localparam logic [3:0] IDX_CURR_TRIM    = 4'h9;

   // ----------------------------------------------------------------
   // Writable masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_COMP_CTRL   = 8'hFF;
   localparam logic [7:0] MASK_MUX         = 8'h3F;
   localparam logic [7:0] MASK_ROUTE       = 8'h03;
   localparam logic [7:0] MASK_SCALER      = 8'h3F;
   localparam logic [7:0] MASK_WINDOW      = 8'h1F;
   localparam logic [7:0] MASK_CURR_CTRL   = 8'hC3;
   localparam logic [7:0] MASK_CURR_TRIM   = 8'h0F;
   localparam logic [7:0] RESET_REG        = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_IRQ_COND    = 6;  // comparator control [7:6]
   localparam int POS_IRQ_LEVEL   = 4;  // comparator control [5:4]
   localparam int POS_ROUTE1      = 1;
   localparam int POS_ROUTE0      = 0;
   localparam int POS_WIN_EN      = 4;
   localparam int POS_WIN_COND    = 2;  // window control [3:2]
   localparam int POS_WIN_LEVEL   = 0;  // window control [1:0]
   localparam int POS_WIN_POS     = 6;  // status [7:6]
   localparam int POS_COMP1_LVL   = 5;
   localparam int POS_COMP0_LVL   = 4;
   localparam int POS_WIN_FLAG    = 2;
   localparam int POS_COMP1_FLAG  = 1;
   localparam int POS_COMP0_FLAG  = 0;
   localparam int POS_CURR_EN     = 7;
   localparam int POS_CURR_COMB   = 6;
   localparam int POS_CURR_OUT1   = 1;
   localparam int POS_CURR_OUT0   = 0;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      EDGE_TOGGLE   = 2'b00,
      EDGE_RESERVED = 2'b01,
      EDGE_FALLING  = 2'b10,
      EDGE_RISING   = 2'b11
   } acw_edge_e;

   typedef enum logic [1:0] {
      WIN_ABOVE   = 2'b00,
      WIN_INSIDE  = 2'b01,
      WIN_BELOW   = 2'b10,
      WIN_OUTSIDE = 2'b11
   } acw_win_e;

   // Settings passed on to the analog pair
   typedef struct packed {
      logic [7:0] comp0_ctrl;
      logic [7:0] comp1_ctrl;
      logic [2:0] comp0_negative_input_select;
      logic [2:0] comp1_negative_input_select;
      logic [2:0] comp0_positive_select;
      logic [2:0] comp1_positive_select;
      logic [5:0] supply_scale_factor;
      logic       window_enable;
      logic       current_enable;
      logic       current_combine;
      logic       comp0_current_out;
      logic       comp1_current_out;
      logic [3:0] current_trim_value;
   } acw_analog_s;

endpackage

/* src/acw_top.sv */
// Digital control and status for a pair of analog comparators.
// Assumes raw comparator outputs arrive asynchronously, vector
// acknowledges come from the interrupt controller on clk.
//
// Overview of operation
// - Route bits put comparator outputs on pins
// - Six-bit factor drives the supply scaler
// - Window mode only while enable bit set
// - Window condition code selects window event
// - Window level enables and prioritises request
// - Window position reported while window enabled
// - Status shows live level of each comparator
// - Window flag set on chosen condition
// - Window vector execution clears window flag
// - Writing one clears a flag; zero keeps
// - Comparator one flag set on chosen edge
// - Comparator one vector clears its flag
// - Comparator zero flag set, vector clears
// - Current source on only when enabled
// - Combine bit doubles each comparator current
// - Current output bit routes to negative pin
// - Edge mode: toggle, falling, rising, reserved
// - Events generated regardless of interrupt enable
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps

module acw_top
   import acw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Analog comparator side
   input  wire logic        comp0_raw,
   input  wire logic        comp1_raw,
   output acw_analog_s      analog_cfg,
   output logic             pin6_out,
   output logic             pin6_oe,
   output logic             pin7_out,
   output logic             pin7_oe,
   // Events and interrupt controller
   output logic             comp0_event,
   output logic             comp1_event,
   output logic             window_event,
   output logic      [1:0]  comp0_irq_req,
   output logic      [1:0]  comp1_irq_req,
   output logic      [1:0]  window_irq_req,
   input  wire logic        comp0_vector_done,
   input  wire logic        comp1_vector_done,
   input  wire logic        window_vector_done
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic edge_hit(input logic [1:0] mode,
                                     input logic       prev,
                                     input logic       now);
      logic hit;
      hit = 1'b0;
      case (mode)
         EDGE_TOGGLE:  hit = prev ^ now;
         EDGE_FALLING: hit = prev & ~now;
         EDGE_RISING:  hit = ~prev & now;
         default:      hit = 1'b0;         // Reserved code never fires
      endcase
      return hit;
   endfunction

   function automatic logic [1:0] win_of(input logic c0, input logic c1);
      logic [1:0] pos;
      pos = WIN_BELOW;
      if (c0)
         pos = WIN_ABOVE;
      else if (c1)
         pos = WIN_INSIDE;
      return pos;
   endfunction

   function automatic logic win_match(input logic [1:0] cond,
                                      input logic [1:0] pos);
      logic m;
      m = 1'b0;
      case (cond)
         WIN_ABOVE:   m = (pos == WIN_ABOVE);
         WIN_INSIDE:  m = (pos == WIN_INSIDE);
         WIN_BELOW:   m = (pos == WIN_BELOW);
         WIN_OUTSIDE: m = (pos != WIN_INSIDE);
         default:     m = 1'b0;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] data,
                                        input logic [7:0] mask);
      return (old & ~mask) | (data & mask);
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Three stages; a level counts once stages two and three agree,
   // which trades one cycle of delay for immunity to a single glitch.
   logic [2:0] sync0;
   logic [2:0] sync1;
   logic       lvl0;
   logic       lvl1;
   logic [2:0] next_sync0;
   logic [2:0] next_sync1;
   logic       next_lvl0;
   logic       next_lvl1;

   always_comb begin
      next_sync0 = {sync0[1:0], comp0_raw};
      next_sync1 = {sync1[1:0], comp1_raw};
      next_lvl0  = (sync0[2] == sync0[1]) ? sync0[2] : lvl0;
      next_lvl1  = (sync1[2] == sync1[1]) ? sync1[2] : lvl1;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync0 <= 3'h0;
         sync1 <= 3'h0;
         lvl0  <= 1'b0;
         lvl1  <= 1'b0;
      end else begin
         sync0 <= next_sync0;
         sync1 <= next_sync1;
         lvl0  <= next_lvl0;
         lvl1  <= next_lvl1;
      end
   end

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // One wait cycle per access so read data can come from a flop.
   logic       ack;
   logic       next_ack;
   logic [3:0] idx;
   logic       wr_go;
   logic       lane0;

   assign idx             = avs_address[5:2];
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_go           = avs_write & ack;
   assign lane0           = avs_byteenable[0];

   always_comb begin
      next_ack = (avs_read | avs_write) & ~ack;
   end

   // ----------------------------------------------------------------
   // Registers, flags and events
   // ----------------------------------------------------------------
   logic [7:0] comp0_ctrl, comp1_ctrl, comp0_mux, comp1_mux;
   logic [7:0] route, scaler, window, curr_ctrl, curr_trim;
   logic       flag0, flag1, flagw;
   logic       prev0, prev1;
   logic [1:0] prev_pos;
   logic       ev0, ev1, evw;
   logic [7:0] next_comp0_ctrl, next_comp1_ctrl, next_comp0_mux;
   logic [7:0] next_comp1_mux, next_route, next_scaler, next_window;
   logic [7:0] next_curr_ctrl, next_curr_trim;
   logic       next_flag0, next_flag1, next_flagw;
   logic [1:0] pos_now;
   logic       win_on;
   logic [7:0] status;
   logic [31:0] rdata;
   logic [31:0] next_rdata;

   assign win_on  = window[POS_WIN_EN];
   assign pos_now = win_of(lvl0, lvl1);

   always_comb begin
      next_comp0_ctrl = comp0_ctrl;
      next_comp1_ctrl = comp1_ctrl;
      next_comp0_mux  = comp0_mux;
      next_comp1_mux  = comp1_mux;
      next_route      = route;
      next_scaler     = scaler;
      next_window     = window;
      next_curr_ctrl  = curr_ctrl;
      next_curr_trim  = curr_trim;
      // Reserved bits stay zero whatever software writes
      if (wr_go && lane0) begin
         case (idx)
            IDX_COMP0_CTRL: next_comp0_ctrl =
               merge(comp0_ctrl, avs_writedata[7:0], MASK_COMP_CTRL);
            IDX_COMP1_CTRL: next_comp1_ctrl =
               merge(comp1_ctrl, avs_writedata[7:0], MASK_COMP_CTRL);
            IDX_COMP0_MUX:  next_comp0_mux =
               merge(comp0_mux, avs_writedata[7:0], MASK_MUX);
            IDX_COMP1_MUX:  next_comp1_mux =
               merge(comp1_mux, avs_writedata[7:0], MASK_MUX);
            IDX_ROUTE:      next_route =
               merge(route, avs_writedata[7:0], MASK_ROUTE);
            IDX_SCALER:     next_scaler =
               merge(scaler, avs_writedata[7:0], MASK_SCALER);
            IDX_WINDOW:     next_window =
               merge(window, avs_writedata[7:0], MASK_WINDOW);
            IDX_CURR_CTRL:  next_curr_ctrl =
               merge(curr_ctrl, avs_writedata[7:0], MASK_CURR_CTRL);
            IDX_CURR_TRIM:  next_curr_trim =
               merge(curr_trim, avs_writedata[7:0], MASK_CURR_TRIM);
            default: begin
            end
         endcase
      end
   end

   // Events fire whatever the interrupt level says
   always_comb begin
      ev0 = edge_hit(comp0_ctrl[POS_IRQ_COND +: 2], prev0, lvl0);
      ev1 = edge_hit(comp1_ctrl[POS_IRQ_COND +: 2], prev1, lvl1);
      // Window event on entry into the chosen condition
      evw = win_on && win_match(window[POS_WIN_COND +: 2], pos_now)
            && !(win_match(window[POS_WIN_COND +: 2], prev_pos)
                 && prev_pos != pos_now) && (prev_pos != pos_now);
   end

   // Set beats any clear arriving in the same cycle
   always_comb begin
      logic clr_st;
      clr_st     = wr_go && lane0 && (idx == IDX_STATUS);
      next_flag0 = flag0;
      next_flag1 = flag1;
      next_flagw = flagw;
      if (comp0_vector_done || (clr_st && avs_writedata[POS_COMP0_FLAG]))
         next_flag0 = 1'b0;
      if (comp1_vector_done || (clr_st && avs_writedata[POS_COMP1_FLAG]))
         next_flag1 = 1'b0;
      if (window_vector_done || (clr_st && avs_writedata[POS_WIN_FLAG]))
         next_flagw = 1'b0;
      if (ev0)
         next_flag0 = 1'b1;
      if (ev1)
         next_flag1 = 1'b1;
      if (evw)
         next_flagw = 1'b1;
   end

   always_comb begin
      status = 8'h00;
      status[POS_WIN_POS +: 2]  = win_on ? pos_now : WIN_ABOVE;
      status[POS_COMP1_LVL]     = lvl1;
      status[POS_COMP0_LVL]     = lvl0;
      status[POS_WIN_FLAG]      = flagw;
      status[POS_COMP1_FLAG]    = flag1;
      status[POS_COMP0_FLAG]    = flag0;
   end

   // Unmapped indexes read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (avs_read && !ack) begin
         case (idx)
            IDX_COMP0_CTRL: next_rdata[7:0] = comp0_ctrl;
            IDX_COMP1_CTRL: next_rdata[7:0] = comp1_ctrl;
            IDX_COMP0_MUX:  next_rdata[7:0] = comp0_mux;
            IDX_COMP1_MUX:  next_rdata[7:0] = comp1_mux;
            IDX_ROUTE:      next_rdata[7:0] = route;
            IDX_SCALER:     next_rdata[7:0] = scaler;
            IDX_WINDOW:     next_rdata[7:0] = window;
            IDX_STATUS:     next_rdata[7:0] = status;
            IDX_CURR_CTRL:  next_rdata[7:0] = curr_ctrl;
            IDX_CURR_TRIM:  next_rdata[7:0] = curr_trim;
            default:        next_rdata = 32'h0000_0000;
         endcase
      end else begin
         next_rdata = rdata;
      end
   end

   assign avs_readdata = rdata;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack        <= 1'b0;
         rdata      <= 32'h0000_0000;
         comp0_ctrl <= RESET_REG;
         comp1_ctrl <= RESET_REG;
         comp0_mux  <= RESET_REG;
         comp1_mux  <= RESET_REG;
         route      <= RESET_REG;
         scaler     <= RESET_REG;
         window     <= RESET_REG;
         curr_ctrl  <= RESET_REG;
         curr_trim  <= RESET_REG;
         flag0      <= 1'b0;
         flag1      <= 1'b0;
         flagw      <= 1'b0;
         prev0      <= 1'b0;
         prev1      <= 1'b0;
         prev_pos   <= WIN_BELOW;
      end else begin
         ack        <= next_ack;
         rdata      <= next_rdata;
         comp0_ctrl <= next_comp0_ctrl;
         comp1_ctrl <= next_comp1_ctrl;
         comp0_mux  <= next_comp0_mux;
         comp1_mux  <= next_comp1_mux;
         route      <= next_route;
         scaler     <= next_scaler;
         window     <= next_window;
         curr_ctrl  <= next_curr_ctrl;
         curr_trim  <= next_curr_trim;   // Loaded by software
         flag0      <= next_flag0;
         flag1      <= next_flag1;
         flagw      <= next_flagw;
         prev0      <= lvl0;
         prev1      <= lvl1;
         prev_pos   <= pos_now;
      end
   end

   // ----------------------------------------------------------------
   // Outputs to analog side, pins and interrupt controller
   // ----------------------------------------------------------------
   acw_analog_s next_cfg;
   logic        next_pin6_out, next_pin6_oe, next_pin7_out, next_pin7_oe;
   logic        next_ev0, next_ev1, next_evw;
   logic [1:0]  next_req0, next_req1, next_reqw;

   always_comb begin
      next_cfg.comp0_ctrl                  = comp0_ctrl;
      next_cfg.comp1_ctrl                  = comp1_ctrl;
      next_cfg.comp0_negative_input_select = comp0_mux[2:0];
      next_cfg.comp1_negative_input_select = comp1_mux[2:0];
      next_cfg.comp0_positive_select       = comp0_mux[5:3];
      next_cfg.comp1_positive_select       = comp1_mux[5:3];
      next_cfg.supply_scale_factor         = scaler[5:0];
      next_cfg.window_enable               = win_on;
      next_cfg.current_enable              = curr_ctrl[POS_CURR_EN];
      next_cfg.current_combine             = curr_ctrl[POS_CURR_COMB];
      // Current leaves on the negative selector pin
      next_cfg.comp0_current_out = curr_ctrl[POS_CURR_EN] & curr_ctrl[POS_CURR_OUT0];
      next_cfg.comp1_current_out = curr_ctrl[POS_CURR_EN] & curr_ctrl[POS_CURR_OUT1];
      next_cfg.current_trim_value          = curr_trim[3:0];
      next_pin6_oe  = route[POS_ROUTE1];
      next_pin6_out = route[POS_ROUTE1] & lvl1;
      next_pin7_oe  = route[POS_ROUTE0];
      next_pin7_out = route[POS_ROUTE0] & lvl0;
      next_ev0 = ev0;
      next_ev1 = ev1;
      next_evw = evw;
      // Level zero keeps the request quiet; flag still kept
      next_req0 = next_flag0 ? comp0_ctrl[POS_IRQ_LEVEL +: 2] : 2'h0;
      next_req1 = next_flag1 ? comp1_ctrl[POS_IRQ_LEVEL +: 2] : 2'h0;
      next_reqw = next_flagw ? window[POS_WIN_LEVEL +: 2] : 2'h0;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         analog_cfg     <= '0;
         pin6_out       <= 1'b0;
         pin6_oe        <= 1'b0;
         pin7_out       <= 1'b0;
         pin7_oe        <= 1'b0;
         comp0_event    <= 1'b0;
         comp1_event    <= 1'b0;
         window_event   <= 1'b0;
         comp0_irq_req  <= 2'h0;
         comp1_irq_req  <= 2'h0;
         window_irq_req <= 2'h0;
      end else begin
         analog_cfg     <= next_cfg;
         pin6_out       <= next_pin6_out;
         pin6_oe        <= next_pin6_oe;
         pin7_out       <= next_pin7_out;
         pin7_oe        <= next_pin7_oe;
         comp0_event    <= next_ev0;
         comp1_event    <= next_ev1;
         window_event   <= next_evw;
         comp0_irq_req  <= next_req0;
         comp1_irq_req  <= next_req1;
         window_irq_req <= next_reqw;
      end
   end

endmodule // acw_top

/* tb/acw_monitor.sv */
// Port checker for the comparator pair window control block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module acw_monitor
   import acw_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        comp0_raw,
   input wire logic        comp1_raw,
   input wire acw_analog_s analog_cfg,
   input wire logic        pin6_out,
   input wire logic        pin6_oe,
   input wire logic        pin7_out,
   input wire logic        pin7_oe,
   input wire logic        comp0_event,
   input wire logic        comp1_event,
   input wire logic        window_event,
   input wire logic [1:0]  comp0_irq_req,
   input wire logic [1:0]  comp1_irq_req,
   input wire logic [1:0]  window_irq_req,
   input wire logic        comp0_vector_done,
   input wire logic        comp1_vector_done,
   input wire logic        window_vector_done
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [3:0] idx;
   logic       wr_ok;
   logic [7:0] wd;
   assign idx   = avs_address[5:2];
   assign wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign wd    = avs_writedata[7:0];
   route_pin_a: assert property ((pin6_out -> pin6_oe) && (pin7_out -> pin7_oe))
      else $error("pin driven while not routed");
   route_write_a: assert property (wr_ok && idx == IDX_ROUTE |=>
      {6'h00, pin6_oe, pin7_oe} == ($past(wd) & 8'h03)
      or ##1 {6'h00, pin6_oe, pin7_oe} == ($past(wd, 2) & 8'h03))
      else $error("route write not seen on pins");
   scale_write_a: assert property (wr_ok && idx == IDX_SCALER |=>
      {2'b00, analog_cfg.supply_scale_factor} == ($past(wd) & 8'h3F)
      or ##1 {2'b00, analog_cfg.supply_scale_factor} == ($past(wd, 2) & 8'h3F))
      else $error("scale factor not passed on");
   window_enable_a: assert property (wr_ok && idx == IDX_WINDOW |=>
      {3'b000, analog_cfg.window_enable, 4'h0} == ($past(wd) & 8'h10)
      or ##1 {3'b000, analog_cfg.window_enable, 4'h0} == ($past(wd, 2) & 8'h10))
      else $error("window enable not passed on");
   current_gate_a: assert property (!analog_cfg.current_enable |->
      !analog_cfg.comp0_current_out && !analog_cfg.comp1_current_out)
      else $error("current output while source off");
   status_read_a: assert property (avs_read && !avs_waitrequest && idx == IDX_STATUS |->
      avs_readdata[7:6] != 2'b11 && (analog_cfg.window_enable || avs_readdata[7:6] == 2'b00))
      else $error("window position wrong in status");
   comp0_req_a: assert property (comp0_event |->
      comp0_irq_req == analog_cfg.comp0_ctrl[5:4])
      else $error("comparator zero request level wrong");
   comp1_req_a: assert property (comp1_event |->
      comp1_irq_req == analog_cfg.comp1_ctrl[5:4])
      else $error("comparator one request level wrong");
endmodule // acw_monitor

bind acw_top acw_monitor u_mon (.*);

/* tb/acw_cmp_model.sv */
// Behavioural pair of analog comparators driving the raw outputs.
// Assumes want changes after rising edges; lag sets answer speed.
`timescale 1ns/1ps
module acw_cmp_model (
   input  wire logic       clk,
   input  wire logic [1:0] want,
   input  wire logic [2:0] lag,
   output logic            comp0_raw,
   output logic            comp1_raw
);
   logic [2:0] cnt;
   initial {cnt, comp1_raw, comp0_raw} = '0;
   // Slow comparator: output moves only after lag cycles
   always @(posedge clk) begin
      if ({comp1_raw, comp0_raw} == want) cnt <= 3'h0;
      else if (cnt >= lag) {comp1_raw, comp0_raw} <= want;
      else cnt <= cnt + 3'h1;
   end
endmodule // acw_cmp_model

/* tb/acw_top_tb.sv */
// Self-checking bench for the comparator pair window control block.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module acw_top_tb;
   import acw_pkg::*;
   logic        clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic        comp0_raw, comp1_raw, pin6_out, pin6_oe, pin7_out, pin7_oe;
   acw_analog_s analog_cfg;
   logic        comp0_event, comp1_event, window_event;
   logic [1:0]  comp0_irq_req, comp1_irq_req, window_irq_req, want;
   logic        comp0_vector_done, comp1_vector_done, window_vector_done;
   logic [2:0]  lag;
   logic [7:0]  q, d, st;
   int          seed, miscompares, n_compared, cycles, n_wev;
   logic [1:0]  steps [4] = '{2'b11, 2'b10, 2'b00, 2'b10};
   acw_top dut (.*);
   acw_cmp_model partner (.clk(clk), .want(want), .lag(lag), .comp0_raw(comp0_raw),
                          .comp1_raw(comp1_raw));
   always #5 clk = ~clk;
   always @(negedge clk) n_wev += window_event;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] msk(input logic [3:0] i);
      case (i)
         IDX_COMP0_CTRL, IDX_COMP1_CTRL: return MASK_COMP_CTRL;
         IDX_COMP0_MUX, IDX_COMP1_MUX:   return MASK_MUX;
         IDX_ROUTE:     return MASK_ROUTE;
         IDX_SCALER:    return MASK_SCALER;
         IDX_WINDOW:    return MASK_WINDOW;
         IDX_CURR_CTRL: return MASK_CURR_CTRL;
         IDX_CURR_TRIM: return MASK_CURR_TRIM;
         default:       return 8'h00;
      endcase
   endfunction
   function automatic logic [1:0] wpos(input logic [1:0] w);
      return w[0] ? 2'b00 : (w[1] ? 2'b01 : 2'b10);
   endfunction
   function automatic logic ehit(input logic [1:0] m, input logic r);
      return m == 2'b00 || (m == 2'b11 && r) || (m == 2'b10 && !r);
   endfunction
   function automatic logic whit(input logic [1:0] m, input logic [1:0] p);
      return m == p || (m == 2'b11 && p != 2'b01);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bus access: raise after an edge, hold until waitrequest is seen low
   task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] v);
      @(posedge clk);
      avs_address   <= {i, 2'b00};
      avs_writedata <= 32'(v);
      avs_read      <= !w;
      avs_write     <= w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic vec(input logic [2:0] v);
      @(posedge clk);
      {window_vector_done, comp1_vector_done, comp0_vector_done} <= v;
      @(posedge clk);
      {window_vector_done, comp1_vector_done, comp0_vector_done} <= '0;
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {clk, resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {comp0_vector_done, comp1_vector_done, window_vector_done, want, lag} = '0;
      {seed, miscompares, n_compared, cycles} = '0;
      avs_byteenable = 4'hF;
      seed = 73;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         acc(1'b0, i[3:0], 8'h00);
         chk(q, RESET_REG);
      end
      repeat (4) for (int i = 0; i < 11; i++) if (i != 7) begin
         d = 8'($random(seed));
         acc(1'b1, i[3:0], d);
         acc(1'b0, i[3:0], 8'h00);
         chk(q, d & msk(i[3:0]));
      end
      acc(1'b1, IDX_SCALER, 8'h3F);
      avs_byteenable <= 4'h0;
      acc(1'b1, IDX_SCALER, 8'h15);
      avs_byteenable <= 4'hF;
      acc(1'b1, IDX_CURR_TRIM, 8'hFA);
      acc(1'b1, IDX_CURR_CTRL, 8'h43);
      wt(3);
      chk({2'b00, analog_cfg.supply_scale_factor}, 8'h3F);
      chk({4'h0, analog_cfg.current_trim_value}, 8'h0A);
      chk({5'h00, analog_cfg.current_enable, analog_cfg.current_combine,
           analog_cfg.comp0_current_out}, 8'h02);
      acc(1'b1, IDX_CURR_CTRL, 8'hC3);
      wt(3);
      chk({6'h00, analog_cfg.comp1_current_out, analog_cfg.comp0_current_out}, 8'h03);
      acc(1'b1, IDX_ROUTE, 8'h03);
      for (int k = 0; k < 8; k++) begin
         acc(1'b1, IDX_WINDOW, {3'b000, k[2], 4'h0});
         @(posedge clk);
         want <= k[1:0];
         lag  <= 3'($random(seed));
         wt(14);
         chk({4'h0, pin6_oe, pin6_out, pin7_oe, pin7_out}, {4'h0, 1'b1, k[1], 1'b1, k[0]});
         acc(1'b0, IDX_STATUS, 8'h00);
         chk(q & 8'hF0, {k[2] ? wpos(k[1:0]) : 2'b00, k[1], k[0], 4'h0});
      end
      acc(1'b1, IDX_WINDOW, 8'h00);
      for (int c = 0; c < 2; c++) for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         want <= 2'b00;
         wt(14);
         acc(1'b1, c[3:0], {m[1:0], 2'b01, 4'h0});
         acc(1'b1, IDX_STATUS, 8'h07);
         for (int r = 1; r >= 0; r--) begin
            @(posedge clk);
            want <= r[0] ? (2'b01 << c) : 2'b00;
            wt(14);
            chk(8'(c[0] ? comp1_irq_req : comp0_irq_req), 8'(ehit(m[1:0], r[0])));
            acc(1'b0, IDX_STATUS, 8'h00);
            chk(q & 8'h03, ehit(m[1:0], r[0]) ? (8'h01 << c) : 8'h00);
            vec({1'b0, c[0], !c[0]});
            acc(1'b0, IDX_STATUS, 8'h00);
            chk(q & 8'h03, 8'h00);
         end
      end
      n_wev = 0;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         want <= 2'b10;
         wt(14);
         acc(1'b1, IDX_WINDOW, {3'b000, 1'b1, m[1:0], 2'b10});
         for (int s = 0; s < 4; s++) begin
            acc(1'b1, IDX_STATUS, 8'h07);
            @(posedge clk);
            want <= steps[s];
            wt(14);
            chk({6'h00, window_irq_req}, whit(m[1:0], wpos(steps[s])) ? 8'h02 : 8'h00);
            acc(1'b0, IDX_STATUS, 8'h00);
            st = q & 8'h04;
            chk(st, whit(m[1:0], wpos(steps[s])) ? 8'h04 : 8'h00);
            acc(1'b1, IDX_STATUS, 8'h00);
            acc(1'b0, IDX_STATUS, 8'h00);
            chk(q & 8'h04, st);
            vec(3'b100);
            acc(1'b0, IDX_STATUS, 8'h00);
            chk(q & 8'h04, 8'h00);
         end
      end
      chk(8'(n_wev), 8'h06);
      tally_and_finish();
   end
endmodule // acw_top_tb
